// >>> hw/sfcl_frame_log.sv
// Serial slave frame qualification, fault flags and transaction record
`timescale 1ns/1ps
`include "sfcl_consts.svh"
module sfcl_frame_log
  import sfcl_pkg::*;
(
  // System
  input wire logic clock,
  input wire logic rstn,
  // Serial link pins
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic sdi,
  output logic sdo_out,
  output logic sdo_oe_n,
  // Device configuration and status
  input wire logic [4:0] group_identifier,
  input wire logic [4:0] revision_code,
  input wire logic [2:0] grade_setting,
  input wire logic [6:0] status_summary,
  input wire logic [12:0] per_switch_status,
  input wire logic link_timeout,
  // Register map handshake
  output logic [6:0] frame_addr,
  input wire logic write_addr_ok,
  input wire logic read_addr_ok,
  input wire logic [12:0] read_data,
  output sfcl_exec_t exec,
  // Fault reporting
  output logic link_fault,
  output sfcl_diag_t diag
);

  // Three-bit checksum, MSB first, over a right-aligned message
  function automatic logic [2:0] crc3(input logic [28:0] msg);
    logic [2:0] c;
    logic fb;
    c = `SFCL_CRC_INIT;
    for (int i = 28; i >= 0; i--) begin
      fb = c[2] ^ msg[i];
      c = {c[1:0], 1'b0} ^ (fb ? `SFCL_CRC_POLY : 3'h0);
    end
    return c;
  endfunction : crc3

  logic [1:0] sclk_m, cs_m, sdi_m;
  logic sclk_s, sclk_d, cs_s, cs_d, sdi_s;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  logic [31:0] rx;
  logic [31:0] next_rx;
  logic [5:0] bit_count;
  logic timed_out;
  logic [23:0] out_shift;
  logic release_out;
  sfcl_kind_t kind;
  logic [6:0] last_addr;
  logic [12:0] last_data;
  logic [12:0] last_rd;
  logic [20:0] body;
  logic [23:0] reply;

  // Two-stage synchronisers for the link pins
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclk_m <= 2'h0;
      cs_m <= 2'h3;
      sdi_m <= 2'h0;
    end else begin
      sclk_m <= {sclk_m[0], sclk};
      cs_m <= {cs_m[0], chip_select_n};
      sdi_m <= {sdi_m[0], sdi};
    end
  end
  assign sclk_s = sclk_m[1];
  assign cs_s = cs_m[1];
  assign sdi_s = sdi_m[1];

  // Delayed copies for edge detection
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_d <= cs_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_d & ~cs_s;
  assign sclk_fall = ~sclk_s & sclk_d & ~cs_s;
  assign cs_fall = ~cs_s & cs_d;
  assign cs_rise = cs_s & ~cs_d;
  assign next_rx = {rx[30:0], sdi_s};

  // Input shift register and clock counter
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx <= 32'h0000_0000;
      bit_count <= 6'h00;
    end else if (cs_fall) begin
      rx <= 32'h0000_0000;
      bit_count <= 6'h00;
    end else if (sclk_rise) begin
      rx <= next_rx;
      if (bit_count != `SFCL_CNT_MAX) begin
        bit_count <= bit_count + 6'h01;
      end
    end
  end

  // Timeout seen during the frame
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timed_out <= 1'b0;
    end else if (cs_fall) begin
      timed_out <= 1'b0;
    end else if (!cs_s && link_timeout) begin
      timed_out <= 1'b1;
    end
  end

  // Frame decode and qualification
  logic is_read, len_bad, crc_bad, wr_bad, rd_bad, non_member, qualified, cfg_read;
  logic [1:0] cmd;
  logic [4:0] id;
  sfcl_diag_t fault;
  assign is_read = rx[31];
  assign cmd = rx[30:29];
  assign id = rx[28:24];
  assign frame_addr = rx[22:16];
  assign len_bad = (bit_count != `SFCL_FRAME_BITS) || timed_out;
  assign crc_bad = crc3(rx[31:3]) != rx[2:0];
  assign wr_bad = !is_read && (cmd == `SFCL_CMD_BAD_LO || cmd == `SFCL_CMD_BAD_HI
                               || !write_addr_ok);
  assign rd_bad = is_read && (rx[15:3] != 13'h0000 || cmd != `SFCL_CMD_READ
                              || !read_addr_ok);
  // Group call for another group without a length fault is ignored here
  assign non_member = !len_bad && !is_read && cmd == `SFCL_CMD_GROUP
                      && id != `SFCL_ID_ALL && id != group_identifier;
  always_comb begin
    fault = '0;
    if (len_bad) begin
      fault.len_err = 1'b1;
    end else if (crc_bad) begin
      fault.crc_err = 1'b1;
    end else if (wr_bad) begin
      fault.wr_err = 1'b1;
    end else if (rd_bad) begin
      fault.rd_err = 1'b1;
    end
  end
  assign qualified = (fault == '0);
  assign cfg_read = qualified && is_read && frame_addr == `SFCL_CFG_ADDR;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      exec <= '0;
    end else begin
      exec.valid <= cs_rise && qualified && !non_member;
      if (cs_rise) begin
        exec.is_read <= is_read;
        exec.addr <= frame_addr;
        exec.data <= rx[15:3];
      end
    end
  end

  // sticky fault flag, dropped by clearing read
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link_fault <= 1'b0;
    end else if (cs_rise && !non_member && !qualified) begin
      link_fault <= 1'b1;
    end else if (cs_rise && cfg_read) begin
      link_fault <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      diag <= '0;
    end else if (cs_rise && !non_member) begin
      diag <= cfg_read ? '0 : (diag | fault);
    end
  end

  // record kind and stored fields at select rise
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      kind <= SFCL_KIND_INIT;
      last_addr <= 7'h00;
      last_data <= 13'h0000;
      last_rd <= 13'h0000;
    end else if (cs_rise && !non_member) begin
      if (!qualified) begin
        kind <= SFCL_KIND_REJ;
      end else if (is_read) begin
        kind <= SFCL_KIND_QR;
        last_addr <= frame_addr;
        last_rd <= read_data;
      end else begin
        kind <= SFCL_KIND_QW;
        last_addr <= frame_addr;
        last_data <= rx[15:3];
      end
    end
  end

  // Reply body chosen by the current mode and the last record kind
  always_comb begin
    body = 21'h000000;
    if (next_rx[7]) begin
      // live status with stored read data
      body = {link_fault, status_summary, last_rd};
    end else begin
      unique case (kind)
        SFCL_KIND_INIT: body = {1'b0, 7'h00, revision_code, grade_setting,
                                `SFCL_INIT_PATTERN};
        SFCL_KIND_REJ: body = {1'b1, 7'h00, 4'h0, diag, 5'h00};
        SFCL_KIND_QW: body = {link_fault, last_addr, last_data};
        SFCL_KIND_QR: body = {link_fault, last_addr, per_switch_status};
        default: body = 21'h000000;
      endcase
    end
  end
  assign reply = {body, crc3({8'h00, body})};

  // group membership decided on the eighth input bit
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      release_out <= 1'b0;
    end else if (cs_fall) begin
      release_out <= 1'b0;
    end else if (sclk_rise && bit_count == `SFCL_HDR_LAST) begin
      release_out <= !next_rx[7] && next_rx[6:5] == `SFCL_CMD_GROUP
                     && next_rx[4:0] != `SFCL_ID_ALL && next_rx[4:0] != group_identifier;
    end
  end

  // Output shift register; group calls load zeros so sdo_out stays low
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      out_shift <= 24'h000000;
    end else if (cs_fall) begin
      out_shift <= 24'h000000;
    end else if (sclk_rise && bit_count == `SFCL_HDR_LAST) begin
      out_shift <= (!next_rx[7] && next_rx[6:5] == `SFCL_CMD_GROUP) ? 24'h000000 : reply;
    end else if (sclk_fall && bit_count >= `SFCL_HDR_BITS) begin
      out_shift <= {out_shift[22:0], 1'b0};
    end
  end

  // output bit, zero through the header
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sdo_out <= 1'b0;
    end else if (cs_fall) begin
      sdo_out <= 1'b0;
    end else if (sclk_fall && bit_count >= `SFCL_HDR_BITS && !release_out) begin
      sdo_out <= out_shift[23];
    end
  end

  // Drive while selected, except after the header of a foreign group call
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sdo_oe_n <= 1'b1;
    end else begin
      sdo_oe_n <= cs_s | (release_out && bit_count >= `SFCL_HDR_BITS);
    end
  end

  // Checks
  sequence s_frame_end;
    cs_rise && !non_member;
  endsequence

  property p_drive_low;
    @(posedge clock) disable iff (!rstn)
      cs_fall |=> ##1 (!sdo_oe_n && !sdo_out);
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("output not low at select");

  property p_release;
    @(posedge clock) disable iff (!rstn)
      (release_out && !cs_s && bit_count >= `SFCL_HDR_BITS) |=> sdo_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("foreign group call drives");

  logic qualified_q;
  property p_exec;
    @(posedge clock) disable iff (!rstn)
      s_frame_end |=> (exec.valid == qualified_q);
  endproperty
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      qualified_q <= 1'b0;
    end else begin
      qualified_q <= qualified;
    end
  end
  a_exec: assert property (p_exec) else $error("execute mismatch");

  property p_fault_set;
    @(posedge clock) disable iff (!rstn)
      (s_frame_end and !qualified) |=> link_fault [*2];
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault flag not set");

  property p_one_fault;
    @(posedge clock) disable iff (!rstn)
      (cs_rise && !cfg_read) |=> $onehot0(diag & ~$past(diag));
  endproperty
  a_one_fault: assert property (p_one_fault) else $error("several faults recorded");

  property p_diag_hold;
    @(posedge clock) disable iff (!rstn)
      (diag != '0 && !(cs_rise && cfg_read)) |=> ((diag & $past(diag)) == $past(diag));
  endproperty
  a_diag_hold: assert property (p_diag_hold) else $error("diagnostic bit dropped");

  property p_len;
    @(posedge clock) disable iff (!rstn)
      (s_frame_end and (bit_count != `SFCL_FRAME_BITS)) |=> (diag.len_err || cfg_read);
  endproperty
  a_len: assert property (p_len) else $error("length fault missing");

  property p_log_kind;
    @(posedge clock) disable iff (!rstn)
      s_frame_end |=> (kind == ($past(qualified) ? ($past(is_read) ? SFCL_KIND_QR :
                       SFCL_KIND_QW) : SFCL_KIND_REJ));
  endproperty
  a_log_kind: assert property (p_log_kind) else $error("record kind wrong");

endmodule : sfcl_frame_log

// >>> include/sfcl_consts.svh
// Constants for the serial frame check and transaction log block
`ifndef SFCL_CONSTS_SVH
`define SFCL_CONSTS_SVH
`define SFCL_FRAME_BITS 6'h20
`define SFCL_HDR_BITS 6'h08
`define SFCL_HDR_LAST 6'h07
`define SFCL_CNT_MAX 6'h3F
`define SFCL_CMD_READ 2'h1
`define SFCL_CMD_GROUP 2'h2
`define SFCL_CMD_BAD_LO 2'h0
`define SFCL_CMD_BAD_HI 2'h3
`define SFCL_ID_ALL 5'h00
`define SFCL_CFG_ADDR 7'h02
`define SFCL_INIT_PATTERN 5'h11
`define SFCL_CRC_POLY 3'h3
`define SFCL_CRC_INIT 3'h0
`endif

// >>> include/sfcl_pkg.sv
// Types shared by the serial frame check and transaction log block
package sfcl_pkg;
  // Kind of the last logged frame
  typedef enum logic [3:0] {
    SFCL_KIND_INIT = 4'h1,
    SFCL_KIND_REJ = 4'h2,
    SFCL_KIND_QW = 4'h4,
    SFCL_KIND_QR = 4'h8
  } sfcl_kind_t;
  // Cumulative diagnostic bits, in precedence order
  typedef struct packed {
    logic len_err;
    logic crc_err;
    logic wr_err;
    logic rd_err;
  } sfcl_diag_t;
  // Executed instruction handed to the register map
  typedef struct packed {
    logic valid;
    logic is_read;
    logic [6:0] addr;
    logic [12:0] data;
  } sfcl_exec_t;
endpackage : sfcl_pkg

// >>> test/sfcl_frame_log_tb_top.sv
// Testbench for the serial frame check and transaction log block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); \
  end \
end
module sfcl_frame_log_tb_top;
  import sfcl_pkg::*;
  logic clock, rstn, sclk, chip_select_n, sdi, sdo_out, sdo_oe_n, link_timeout;
  logic write_addr_ok, read_addr_ok, link_fault;
  logic [4:0] group_identifier, revision_code;
  logic [2:0] grade_setting;
  logic [6:0] status_summary, frame_addr;
  logic [12:0] per_switch_status, read_data;
  sfcl_exec_t exec, last_exec;
  sfcl_diag_t diag;
  int failures, comparisons, pulses;
  logic [31:0] got, oe_seen;
  // Clock and starting values of the device inputs
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    {rstn, link_timeout, failures, comparisons} = '0;
    {write_addr_ok, read_addr_ok} = 2'h3;
    group_identifier = 5'h05;
    revision_code = 5'h0A; // Arbitrary revision value
    grade_setting = 3'h5;
    status_summary = 7'h2C;
    per_switch_status = 13'h1A5B;
    read_data = 13'h00AB;
  end
  sfcl_frame_log sfcl_frame_log_inst (.clock(clock), .rstn(rstn), .sclk(sclk),
    .chip_select_n(chip_select_n), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
    .group_identifier(group_identifier), .revision_code(revision_code),
    .grade_setting(grade_setting), .status_summary(status_summary),
    .per_switch_status(per_switch_status), .link_timeout(link_timeout),
    .frame_addr(frame_addr), .write_addr_ok(write_addr_ok), .read_addr_ok(read_addr_ok),
    .read_data(read_data), .exec(exec), .link_fault(link_fault), .diag(diag));
  sfcl_master_model sfcl_master_model_inst (.sclk(sclk), .chip_select_n(chip_select_n),
    .sdi(sdi), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n));
  // Count execute pulses and keep the last one
  always @(posedge clock) begin
    if (exec.valid === 1'b1) begin
      pulses <= pulses + 1;
      last_exec <= exec;
    end
  end
  // Checksum x^3+x+1, zero start, MSB first over n bits
  function automatic logic [2:0] crc3(input logic [28:0] m, input int n);
    logic [2:0] c;
    logic fb;
    c = 3'h0;
    for (int i = n - 1; i >= 0; i--) begin
      fb = m[i] ^ c[2];
      c = {c[1:0], 1'b0} ^ (fb ? 3'h3 : 3'h0);
    end
    return c;
  endfunction : crc3
  function automatic logic [31:0] mk(input logic rd, input logic [1:0] cmd,
                                     input logic [4:0] id, input logic [6:0] a,
                                     input logic [12:0] d);
    return {rd, cmd, id, 1'b0, a, d, crc3({rd, cmd, id, 1'b0, a, d}, 29)};
  endfunction : mk
  function automatic logic [31:0] rep(input logic [20:0] b);
    return {8'h00, b, crc3({8'h00, b}, 21)};
  endfunction : rep
  // Run one frame, then check the reply of a 32-bit frame and the execute count
  task automatic xfer(input logic [31:0] w, input int n, input logic [31:0] er,
                      input int ep);
    int p0;
    p0 = pulses;
    @(posedge clock);
    #1;
    sfcl_master_model_inst.frame(w, n, got, oe_seen);
    repeat (8) @(posedge clock);
    #1;
    if (n == 32) `CHK("reply", er, got)
    `CHK("exec pulses", ep, pulses - p0)
  endtask : xfer
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // Watchdog
  initial begin
    #150000;
    failures++;
    conclude();
  end
  // Test sequence
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    repeat (5) @(posedge clock);
    xfer(mk(0, 2'h1, 0, 7'h05, 13'h0123), 32, rep({8'h0, 5'h0A, 3'h5, 5'h11}), 1);
    `CHK("exec addr", 7'h05, last_exec.addr)
    `CHK("exec data", 13'h0123, last_exec.data)
    `CHK("frame addr", 7'h05, frame_addr)
    xfer(mk(0, 2'h1, 0, 7'h06, 13'h0456), 32, rep({1'b0, 7'h05, 13'h0123}), 1);
    xfer(mk(0, 2'h2, 5'h05, 7'h07, 13'h0789), 32, 32'h0, 1);
    `CHK("own group oe", 32'h0, oe_seen)
    xfer(mk(0, 2'h2, 5'h03, 7'h09, 13'h0001), 32, 32'h00FFFFFF, 0);
    `CHK("foreign group oe", 32'h00FFFFFF, oe_seen)
    xfer(mk(0, 2'h1, 0, 7'h0A, 13'h0002) ^ 32'h1, 32, rep({1'b0, 7'h07, 13'h0789}), 0);
    `CHK("fault flag", 1'b1, link_fault)
    `CHK("diag crc", 4'h4, diag)
    // Both bad write call types accumulate one write fault
    for (int k = 0; k < 2; k++) begin
      xfer(mk(0, 2'(k * 3), 0, 7'h0B, 13'h0003), 32,
           rep({1'b1, 11'h0, k ? 4'h6 : 4'h4, 5'h0}), 0);
      `CHK("diag write", 4'h6, diag)
    end
    // Short frame with a bad checksum counts only as length
    xfer(mk(0, 2'h1, 0, 7'h0C, 13'h0004) ^ 32'h2, 31, 32'h0, 0);
    `CHK("diag length", 4'hE, diag)
    xfer(mk(1, 2'h1, 0, 7'h02, 13'h0001), 32, rep({1'b1, 7'h2C, 13'h0}), 0);
    `CHK("diag read", 4'hF, diag)
    xfer(mk(0, 2'h1, 0, 7'h08, 13'h0AAA), 32, rep({1'b1, 11'h0, 4'hF, 5'h0}), 1);
    `CHK("flag kept", 1'b1, link_fault)
    xfer(mk(1, 2'h1, 0, 7'h02, 13'h0), 32, rep({1'b1, 7'h2C, 13'h0}), 1);
    `CHK("diag cleared", 4'h0, diag)
    `CHK("read exec", 1'b1, last_exec.is_read)
    xfer(mk(0, 2'h1, 0, 7'h09, 13'h0005), 32, rep({1'b0, 7'h02, 13'h1A5B}), 1);
    xfer(mk(1, 2'h1, 0, 7'h02, 13'h0), 32, rep({1'b0, 7'h2C, 13'h00AB}), 1);
    // Register map refuses a write address
    @(posedge clock);
    write_addr_ok <= 1'b0;
    xfer(mk(0, 2'h1, 0, 7'h0D, 13'h0006), 32, rep({1'b0, 7'h02, 13'h1A5B}), 0);
    `CHK("diag bad write", 4'h2, diag)
    // Register map refuses a read address
    @(posedge clock);
    {write_addr_ok, read_addr_ok} <= 2'h2;
    xfer(mk(1, 2'h1, 0, 7'h0E, 13'h0), 32, rep({1'b1, 7'h2C, 13'h00AB}), 0);
    `CHK("diag bad read", 4'h3, diag)
    // Timeout during an otherwise good frame
    @(posedge clock);
    {write_addr_ok, read_addr_ok, link_timeout} <= 3'h7;
    xfer(mk(0, 2'h1, 0, 7'h10, 13'h0007), 32, rep({1'b1, 11'h0, 4'h3, 5'h0}), 0);
    `CHK("diag timeout", 4'hB, diag)
    // General call keeps the line low and executes
    @(posedge clock);
    link_timeout <= 1'b0;
    xfer(mk(0, 2'h2, 0, 7'h11, 13'h0008), 32, 32'h0, 1);
    `CHK("general call oe", 32'h0, oe_seen)
    `CHK("flag after group call", 1'b1, link_fault)
    conclude();
  end
endmodule : sfcl_frame_log_tb_top

// >>> test/sfcl_master_model.sv
// Serial bus master model that frames words and captures the reply
`timescale 1ns/1ps
module sfcl_master_model (
  // Serial pins driven by the master
  output logic sclk,
  output logic chip_select_n,
  output logic sdi,
  // Reply pins from the device
  input wire logic sdo_out,
  input wire logic sdo_oe_n
);
  // Idle: select high, clock stands low
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    sdi = 1'b0;
  end
  // One frame of n bits, MSB first, 125 ns clock period
  task automatic frame(input logic [31:0] w, input int n, output logic [31:0] rx,
                       output logic [31:0] oe);
    rx = '0;
    oe = '0;
    chip_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = w[31 - (i % 32)];
      #62.5;
      // Released line is pulled up
      rx = {rx[30:0], sdo_oe_n ? 1'b1 : sdo_out};
      oe = {oe[30:0], sdo_oe_n};
      sclk = 1'b1;
      #62.5;
      sclk = 1'b0;
    end
    #62.5;
    chip_select_n = 1'b1;
    sdi = ~sdi; // Released data shows no stale bit
  endtask : frame
endmodule : sfcl_master_model
